/* File: src/usfc_pkg.sv */
// Purpose: shared constants for the uart status and flow control block
// Assumes: 8-bit register port, one clock
// Notes:   offsets are local choices
package usfc_pkg;
    localparam logic [3:0] ADDR_IER      = 4'h1;
    localparam logic [3:0] ADDR_FCR      = 4'h2;
    localparam logic [3:0] ADDR_MCR      = 4'h4;
    localparam logic [3:0] ADDR_LSR      = 4'h5;
    localparam logic [3:0] ADDR_MSR      = 4'h6;
    localparam logic [3:0] ADDR_SCRATCH  = 4'h7;
    localparam logic [3:0] ADDR_EFR      = 4'h8;
    localparam logic [3:0] ADDR_XCHAR1   = 4'h9;
    localparam logic [3:0] ADDR_XCHAR2   = 4'ha;
    localparam logic [3:0] ADDR_RXPUSH   = 4'hb;
    localparam logic [3:0] ADDR_RXPOP    = 4'hc;
    localparam logic [3:0] ADDR_TXCTRL   = 4'hd;
    localparam logic [3:0] ADDR_ENH      = 4'he;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_OP2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_IRDA = 6;
    localparam int MCR_PRESC = 7;
    localparam int EFR_ENH = 4;
    localparam int EFR_ACTS = 7;
    localparam int IER_MS = 3;
    localparam int IER_THR = 1;
    localparam logic [7:0] MCR_ENH_MASK = 8'he0;
    localparam logic [7:0] IER_ENH_MASK = 8'hf0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] FIFO_AW = 4'h4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [3:0] PRE16_LAST = 4'hf;
    localparam logic [1:0] PRE4_LAST = 2'h3;
    localparam int ST_PE = 8;
    localparam int ST_FE = 9;
    localparam int ST_BI = 10;
    typedef enum logic [1:0] {
        USFC_TX_IDLE = 2'b00,
        USFC_TX_SHIFT = 2'b01,
        USFC_TX_HOLD = 2'b11
    } usfc_tx_e;
endpackage

/* File: src/usfc_fifo_if.sv */
// Purpose: push/pop bundle between the top and the receive memory
// Assumes: single clock
// Notes:   entries carry data plus error tags
`timescale 1ns/100ps
interface usfc_fifo_if;
    logic        push;
    logic        pop;
    logic [10:0] wdata;
    logic [10:0] head;
    logic        empty;
    logic        full;
    logic [4:0]  count;
    modport owner (output push, output pop, output wdata,
                   input head, input empty, input full, input count);
    modport mem (input push, input pop, input wdata,
                 output head, output empty, output full, output count);
endinterface

/* File: src/usfc_rx_mem.sv */
// Purpose: receive memory holding data and per-character error tags
// Assumes: pushes when full are dropped by the owner
// Notes:   head comes out of a register
`timescale 1ns/100ps
module usfc_rx_mem (
    input wire logic clock,
    input wire logic rst,
    usfc_fifo_if.mem f
);
    logic [10:0] store [usfc_pkg::FIFO_DEPTH];
    logic [3:0]  wr_ptr;
    logic [3:0]  rd_ptr;
    logic [4:0]  count;
    logic        do_push;
    logic        do_pop;

    assign do_push = f.push && (count != 5'(usfc_pkg::FIFO_DEPTH));
    assign do_pop  = f.pop && (count != 5'h00);
    assign f.empty = (count == 5'h00);
    assign f.full  = (count == 5'(usfc_pkg::FIFO_DEPTH));
    assign f.count = count;

    always_ff @(posedge clock) begin
        if (do_push) begin
            store[wr_ptr] <= f.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count  <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            count <= count + 5'(do_push) - 5'(do_pop);
        end
    end

    // head register loads the entry at the next read pointer, or wdata on a push when empty
    always_ff @(posedge clock) begin
        if (rst) begin
            f.head <= 11'h000;
        end else if (count == 5'h00 && do_push) begin
            f.head <= f.wdata;
        end else begin
            f.head <= store[rd_ptr + 4'(do_pop)];
        end
    end
endmodule

/* File: src/usfc_prescaler.sv */
// Purpose: baud generator input tick, divide by 16 then optional 4
// Assumes: runs every clock
// Notes:   tick is a one-cycle pulse
`timescale 1ns/100ps
module usfc_prescaler (
    input wire logic clock,
    input wire logic rst,
    input wire logic div4,
    output logic     tick
);
    logic [3:0] cnt16;
    logic [1:0] cnt4;
    logic       wrap16;

    assign wrap16 = (cnt16 == usfc_pkg::PRE16_LAST);

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt16 <= 4'h0;
            cnt4  <= 2'h0;
        end else begin
            cnt16 <= cnt16 + 4'h1;
            if (wrap16) begin
                cnt4 <= cnt4 + 2'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= wrap16 && (!div4 || cnt4 == usfc_pkg::PRE4_LAST);
        end
    end
endmodule

/* File: src/usfc_top.sv */
// Purpose: uart channel status, modem status and flow control logic
// Assumes: character engines outside report events as one-cycle pulses
// Notes:   register port reads answer one cycle after the strobe
//
// Summary of operation
// - irda select routes data, idle tx low
// - clock divided by 16, optionally 4 more
// - data ready while receive data held
// - overrun when full, fifo kept intact
// - parity error follows head character
// - framing error follows head character
// - break flagged, one break char per break
// - holding empty set on transfer, cleared on write
// - transmitter empty when holding and shifter empty
// - fifo error summary, cleared by status read
// - modem line change bits, cleared on read
// - ring change only on rising ring input
// - upper modem bits inverted inputs or loopback
// - auto cts stops after current character
// - scratch register, eight bits, no side effects
// - upper flow bits select transmit characters
// - lower flow bits select receive compare
// - dual mode joins both characters as sequence
// - enhanced bit gates, saves, restores fields
// - reset clears enhanced fields
// - loopback bit enters internal loopback
`timescale 1ns/100ps
module usfc_top (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    output logic [7:0]      rdata,
    input wire logic        cts_n,
    input wire logic        dsr_n,
    input wire logic        ri_n,
    input wire logic        cd_n,
    output logic            rts_n,
    output logic            dtr_n,
    input wire logic        ser_rx,
    input wire logic        irda_rx,
    input wire logic        tx_line,
    output logic            ser_tx,
    output logic            irda_tx,
    output logic            core_rx,
    output logic            baud_tick,
    input wire logic        tsr_done,
    output logic            tsr_load,
    output logic [7:0]      tsr_data,
    input wire logic        tsr_busy,
    output logic [1:0]      tx_flow_sel,
    output logic [1:0]      rx_cmp_sel,
    output logic            dual_seq,
    output logic [15:0]     flow_chars,
    output logic            modem_irq,
    output logic            thr_irq
);
    usfc_fifo_if rxf ();

    logic [7:0]  modem_control;
    logic [7:0]  enhanced_feature;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  saved_mcr;
    logic [7:0]  saved_ier;
    logic [7:0]  saved_fcr;
    logic [7:0]  scratch;
    logic [7:0]  xchar1;
    logic [7:0]  xchar2;
    logic [7:0]  transmit_holding;
    logic        thr_full;
    logic        overrun;
    logic        fifo_err;
    logic        in_break;
    logic [3:0]  delta;
    logic [3:0]  lvl_prev;
    logic [3:0]  lvl_now;
    logic [7:0]  line_status;
    logic [7:0]  modem_status;
    logic        loopback;
    logic        cts_stop;
    logic        enh;
    logic        rx_push_ok;
    usfc_pkg::usfc_tx_e tx_state;
    usfc_pkg::usfc_tx_e next_tx_state;

    function automatic logic hit(input logic [3:0] a, input logic strobe,
                                 input logic [3:0] target);
        hit = strobe && (a == target);
    endfunction

    usfc_rx_mem u_mem (
        .clock (clock),
        .rst   (rst),
        .f     (rxf)
    );

    usfc_prescaler u_pre (
        .clock (clock),
        .rst   (rst),
        .div4  (modem_control[usfc_pkg::MCR_PRESC]),
        .tick  (baud_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // line routing and modem outputs
    assign loopback = modem_control[usfc_pkg::MCR_LOOP];
    assign enh      = enhanced_feature[usfc_pkg::EFR_ENH];

    always_comb begin
        // irda pulses mark low bits, so an idle high line gives low out
        if (modem_control[usfc_pkg::MCR_IRDA]) begin
            irda_tx = loopback ? 1'b0 : ~tx_line;
            ser_tx  = 1'b1;
            core_rx = loopback ? tx_line : ~irda_rx;
        end else begin
            irda_tx = 1'b0;
            ser_tx  = loopback ? 1'b1 : tx_line;
            core_rx = loopback ? tx_line : ser_rx;
        end
    end

    assign rts_n = loopback | ~modem_control[usfc_pkg::MCR_RTS];
    assign dtr_n = loopback | ~modem_control[usfc_pkg::MCR_DTR];

    ////////////////////////////////////////////////////////////////////////
    // control registers with enhanced latch
    always_ff @(posedge clock) begin
        if (rst) begin
            modem_control    <= usfc_pkg::ZERO8;
            interrupt_enable_reg              <= usfc_pkg::ZERO8;
            fifo_control_reg              <= usfc_pkg::ZERO8;
            enhanced_feature <= usfc_pkg::ZERO8;
            saved_mcr        <= usfc_pkg::ZERO8;
            saved_ier        <= usfc_pkg::ZERO8;
            saved_fcr        <= usfc_pkg::ZERO8;
        end else if (wr) begin
            case (addr)
                usfc_pkg::ADDR_MCR: modem_control <= enh ? wdata :
                    (wdata & ~usfc_pkg::MCR_ENH_MASK)
                    | (modem_control & usfc_pkg::MCR_ENH_MASK);
                usfc_pkg::ADDR_IER: interrupt_enable_reg <= enh ? wdata :
                    (wdata & ~usfc_pkg::IER_ENH_MASK)
                    | (interrupt_enable_reg & usfc_pkg::IER_ENH_MASK);
                usfc_pkg::ADDR_FCR: fifo_control_reg <= enh ? wdata :
                    (wdata & ~usfc_pkg::FCR_ENH_MASK)
                    | (fifo_control_reg & usfc_pkg::FCR_ENH_MASK);
                usfc_pkg::ADDR_EFR: begin
                    enhanced_feature <= wdata;
                    if (enh && !wdata[usfc_pkg::EFR_ENH]) begin
                        saved_mcr     <= modem_control & usfc_pkg::MCR_ENH_MASK;
                        saved_ier     <= interrupt_enable_reg & usfc_pkg::IER_ENH_MASK;
                        saved_fcr     <= fifo_control_reg & usfc_pkg::FCR_ENH_MASK;
                        modem_control <= modem_control & ~usfc_pkg::MCR_ENH_MASK;
                        interrupt_enable_reg           <= interrupt_enable_reg & ~usfc_pkg::IER_ENH_MASK;
                        fifo_control_reg           <= fifo_control_reg & ~usfc_pkg::FCR_ENH_MASK;
                    end else if (!enh && wdata[usfc_pkg::EFR_ENH]) begin
                        modem_control <= modem_control | saved_mcr;
                        interrupt_enable_reg           <= interrupt_enable_reg | saved_ier;
                        fifo_control_reg           <= fifo_control_reg | saved_fcr;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            scratch <= usfc_pkg::ZERO8;
            xchar1  <= usfc_pkg::ZERO8;
            xchar2  <= usfc_pkg::ZERO8;
        end else begin
            if (hit(addr, wr, usfc_pkg::ADDR_SCRATCH)) begin
                scratch <= wdata;
            end
            if (hit(addr, wr, usfc_pkg::ADDR_XCHAR1)) begin
                xchar1 <= wdata;
            end
            if (hit(addr, wr, usfc_pkg::ADDR_XCHAR2)) begin
                xchar2 <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software flow selection
    assign tx_flow_sel = enhanced_feature[3:2];
    assign rx_cmp_sel  = enhanced_feature[1:0];
    assign dual_seq    = (enhanced_feature[3:2] == 2'b11)
                      || (enhanced_feature[1:0] == 2'b11);
    assign flow_chars  = {xchar1, xchar2};

    ////////////////////////////////////////////////////////////////////////
    // receive side: write of {brk,fe,pe,in_break} at ADDR_RXPUSH, data taken from xchar1
    assign rx_push_ok = hit(addr, wr, usfc_pkg::ADDR_RXPUSH);
    assign rxf.push   = rx_push_ok && !rxf.full
                     && !(wdata[0] && in_break);
    assign rxf.wdata  = {wdata[3:1], xchar1};
    assign rxf.pop    = hit(addr, rd, usfc_pkg::ADDR_RXPOP);

    always_ff @(posedge clock) begin
        if (rst) begin
            in_break <= 1'b0;
        end else if (rx_push_ok) begin
            in_break <= wdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            overrun  <= 1'b0;
            fifo_err <= 1'b0;
        end else begin
            if (rx_push_ok && rxf.full) begin
                overrun <= 1'b1;
            end else if (hit(addr, rd, usfc_pkg::ADDR_LSR)) begin
                overrun <= 1'b0;
            end
            if (rxf.push && (wdata[3:1] != 3'h0)) begin
                fifo_err <= 1'b1;
            end else if (hit(addr, rd, usfc_pkg::ADDR_LSR)) begin
                fifo_err <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit holding and shifter hand-off
    always_comb begin
        case (tx_state)
            usfc_pkg::USFC_TX_IDLE:
                next_tx_state = thr_full ? usfc_pkg::USFC_TX_HOLD
                                         : usfc_pkg::USFC_TX_IDLE;
            usfc_pkg::USFC_TX_HOLD:
                next_tx_state = (!tsr_busy && !cts_stop)
                              ? usfc_pkg::USFC_TX_SHIFT
                              : usfc_pkg::USFC_TX_HOLD;
            usfc_pkg::USFC_TX_SHIFT:
                next_tx_state = tsr_done ? usfc_pkg::USFC_TX_IDLE
                                         : usfc_pkg::USFC_TX_SHIFT;
            default: next_tx_state = usfc_pkg::USFC_TX_IDLE;
        endcase
    end

    // stop only between characters
    assign cts_stop = enhanced_feature[usfc_pkg::EFR_ACTS]
                   && !modem_status[4];
    assign tsr_load = (tx_state == usfc_pkg::USFC_TX_HOLD)
                   && (next_tx_state == usfc_pkg::USFC_TX_SHIFT);
    assign tsr_data = transmit_holding;

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_state <= usfc_pkg::USFC_TX_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            transmit_holding      <= usfc_pkg::ZERO8;
            thr_full <= 1'b0;
        end else if (hit(addr, wr, usfc_pkg::ADDR_TXCTRL)) begin
            transmit_holding      <= wdata;
            thr_full <= 1'b1;
        end else if (tsr_load) begin
            thr_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem status
    always_comb begin
        if (loopback) begin
            lvl_now = {modem_control[usfc_pkg::MCR_OP2],
                       modem_control[usfc_pkg::MCR_OP1],
                       modem_control[usfc_pkg::MCR_DTR],
                       modem_control[usfc_pkg::MCR_RTS]};
        end else begin
            lvl_now = ~{cd_n, ri_n, dsr_n, cts_n};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lvl_prev <= 4'h0;
            delta    <= 4'h0;
        end else begin
            lvl_prev <= lvl_now;
            // set wins over the read clear
            delta[0] <= (lvl_now[0] ^ lvl_prev[0])
                     || (delta[0] && !hit(addr, rd, usfc_pkg::ADDR_MSR));
            delta[1] <= (lvl_now[1] ^ lvl_prev[1])
                     || (delta[1] && !hit(addr, rd, usfc_pkg::ADDR_MSR));
            delta[2] <= (!lvl_now[2] && lvl_prev[2])
                     || (delta[2] && !hit(addr, rd, usfc_pkg::ADDR_MSR));
            delta[3] <= (lvl_now[3] ^ lvl_prev[3])
                     || (delta[3] && !hit(addr, rd, usfc_pkg::ADDR_MSR));
        end
    end

    assign modem_status = {lvl_now, delta};
    assign modem_irq    = interrupt_enable_reg[usfc_pkg::IER_MS] && (delta != 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // line status and read port
    assign line_status = {fifo_err,
                          !thr_full && tx_state != usfc_pkg::USFC_TX_SHIFT,
                          !thr_full,
                          !rxf.empty && rxf.head[usfc_pkg::ST_BI],
                          !rxf.empty && rxf.head[usfc_pkg::ST_FE],
                          !rxf.empty && rxf.head[usfc_pkg::ST_PE],
                          overrun,
                          !rxf.empty};
    assign thr_irq = interrupt_enable_reg[usfc_pkg::IER_THR] && !thr_full;

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= usfc_pkg::ZERO8;
        end else if (rd) begin
            case (addr)
                usfc_pkg::ADDR_IER:     rdata <= interrupt_enable_reg;
                usfc_pkg::ADDR_FCR:     rdata <= fifo_control_reg;
                usfc_pkg::ADDR_MCR:     rdata <= modem_control;
                usfc_pkg::ADDR_LSR:     rdata <= line_status;
                usfc_pkg::ADDR_MSR:     rdata <= modem_status;
                usfc_pkg::ADDR_SCRATCH: rdata <= scratch;
                usfc_pkg::ADDR_EFR:     rdata <= enhanced_feature;
                usfc_pkg::ADDR_XCHAR1:  rdata <= xchar1;
                usfc_pkg::ADDR_XCHAR2:  rdata <= xchar2;
                usfc_pkg::ADDR_RXPOP:   rdata <= rxf.head[7:0];
                default:                rdata <= usfc_pkg::ZERO8;
            endcase
        end else begin
            rdata <= usfc_pkg::ZERO8;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_irda_idle_low: assert property (@(posedge clock) disable iff (rst)
        modem_control[usfc_pkg::MCR_IRDA] && tx_line |-> !irda_tx)
        else $error("irda tx not low");
    chk_dr_tracks: assert property (@(posedge clock) disable iff (rst)
        line_status[0] == (rxf.count != 5'h00))
        else $error("data ready wrong");
    chk_overrun_set: assert property (@(posedge clock) disable iff (rst)
        rx_push_ok && rxf.full |=> overrun && rxf.full)
        else $error("overrun not flagged");
    chk_thr_clear: assert property (@(posedge clock) disable iff (rst)
        hit(addr, wr, usfc_pkg::ADDR_TXCTRL) |=> !line_status[5])
        else $error("holding empty not cleared");
    chk_temt_implies: assert property (@(posedge clock) disable iff (rst)
        line_status[6] |-> line_status[5])
        else $error("tx empty while holding full");
    chk_err_clear: assert property (@(posedge clock) disable iff (rst)
        hit(addr, rd, usfc_pkg::ADDR_LSR) && !rxf.push |=> !fifo_err)
        else $error("error summary not cleared");
    chk_cts_delta: assert property (@(posedge clock) disable iff (rst)
        $changed(lvl_now[0]) |=> delta[0])
        else $error("cts change missed");
    chk_ring_edge: assert property (@(posedge clock) disable iff (rst)
        $rose(lvl_now[2]) && !delta[2] |=> !delta[2])
        else $error("ring change on wrong edge");
    chk_cts_hold: assert property (@(posedge clock) disable iff (rst)
        cts_stop |-> !tsr_load)
        else $error("load while cts stopped");
    chk_ms_irq: assert property (@(posedge clock) disable iff (rst)
        hit(addr, rd, usfc_pkg::ADDR_MSR) && !$changed(lvl_now)
        ##1 !$changed(lvl_now) |-> !modem_irq)
        else $error("modem irq stuck");
endmodule

/* File: testbench/usfc_modem_model.sv */
// Purpose: modem side of the channel, drives the active-low status lines
// Assumes: lines change just after a rising clock edge
// Notes:   receive lines rest at their idle levels
`timescale 1ns/100ps
module usfc_modem_model (
    input wire logic clock,
    output logic     cts_n,
    output logic     dsr_n,
    output logic     ri_n,
    output logic     cd_n,
    output logic     ser_rx,
    output logic     irda_rx
);
    initial begin
        {cts_n, dsr_n, ri_n, cd_n} = 4'hf;
        ser_rx = 1'b1;
        irda_rx = 1'b0;
    end
    // order is cts, dsr, ri, cd; cts high pauses the far sender
    task automatic set_lines(input logic [3:0] v);
        @(posedge clock);
        {cts_n, dsr_n, ri_n, cd_n} <= v;
    endtask
endmodule

/* File: testbench/uart_status_flow_control_bench.sv */
// Purpose: register level checks of status, modem and flow logic
// Assumes: reads answer one cycle after the strobe
// Notes:   the shifter handshake is driven here by hand
`timescale 1ns/100ps
module uart_status_flow_control_bench;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, tx_line = 1'b1;
    logic        tsr_done = 1'b0, tsr_busy = 1'b0;
    logic        cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, ser_rx, irda_rx;
    logic        ser_tx, irda_tx, core_rx, baud_tick, tsr_load;
    logic        modem_irq, thr_irq, dual_seq;
    logic [7:0]  rdata, tsr_data;
    logic [1:0]  tx_flow_sel, rx_cmp_sel;
    logic [15:0] flow_chars;
    int          fails = 0, total_checks = 0, n;
    logic [7:0]  lmap [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
    logic [7:0]  etag [3] = '{8'h02, 8'h04, 8'h09};
    logic [7:0]  elsr [3] = '{8'he5, 8'he9, 8'hf1};
    usfc_top usfc_top_i (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .cts_n, .dsr_n, .ri_n, .cd_n, .rts_n, .dtr_n, .ser_rx, .irda_rx,
        .tx_line, .ser_tx, .irda_tx, .core_rx, .baud_tick, .tsr_done,
        .tsr_load, .tsr_data, .tsr_busy, .tx_flow_sel, .rx_cmp_sel,
        .dual_seq, .flow_chars, .modem_irq, .thr_irq);
    usfc_modem_model usfc_modem_model_i (.clock, .cts_n, .dsr_n, .ri_n,
        .cd_n, .ser_rx, .irda_rx);
    always #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic ml(input logic [3:0] v);
        usfc_modem_model_i.set_lines(v);
        repeat (4) @(posedge clock);
    endtask
    task automatic tick_gap(input int exp);
        @(posedge baud_tick);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (baud_tick !== 1'b1 && n < 200);
        chk(n, exp);
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        chk({rts_n, dtr_n}, 2'b11);
        rreg(usfc_pkg::ADDR_MCR, 8'h00);
        rreg(usfc_pkg::ADDR_LSR, 8'h60);
        rreg(usfc_pkg::ADDR_MSR, 8'h00);
        tick_gap(16);
        wreg(usfc_pkg::ADDR_SCRATCH, 8'ha5);
        rreg(usfc_pkg::ADDR_SCRATCH, 8'ha5);
        rreg(usfc_pkg::ADDR_MCR, 8'h00);
        wreg(usfc_pkg::ADDR_MCR, 8'hc0);
        rreg(usfc_pkg::ADDR_MCR, 8'h00);
        wreg(usfc_pkg::ADDR_EFR, 8'h10);
        wreg(usfc_pkg::ADDR_MCR, 8'hc0);
        rreg(usfc_pkg::ADDR_MCR, 8'hc0);
        @(posedge baud_tick);
        tick_gap(64);
        chk(irda_tx, 1'b0);
        wreg(usfc_pkg::ADDR_EFR, 8'h00);
        rreg(usfc_pkg::ADDR_MCR, 8'h00);
        chk(ser_tx, 1'b1);
        wreg(usfc_pkg::ADDR_EFR, 8'h10);
        rreg(usfc_pkg::ADDR_MCR, 8'hc0);
        wreg(usfc_pkg::ADDR_MCR, 8'h00);
        // modem change bits and interrupt
        wreg(usfc_pkg::ADDR_IER, 8'h08);
        ml(4'h7);
        chk(modem_irq, 1'b1);
        rreg(usfc_pkg::ADDR_MSR, 8'h11);
        rreg(usfc_pkg::ADDR_MSR, 8'h10);
        chk(modem_irq, 1'b0);
        ml(4'h5);
        rreg(usfc_pkg::ADDR_MSR, 8'h50);
        ml(4'h7);
        rreg(usfc_pkg::ADDR_MSR, 8'h14);
        ml(4'h2);
        rreg(usfc_pkg::ADDR_MSR, 8'hba);
        ml(4'hf);
        rreg(usfc_pkg::ADDR_MSR, 8'h0b);
        for (n = 0; n < 4; n++) begin
            wreg(usfc_pkg::ADDR_MCR, 8'h10 | (8'h01 << n));
            rreg(usfc_pkg::ADDR_MSR, lmap[n], 8'hf0);
            chk({rts_n, dtr_n}, 2'b11);
        end
        wreg(usfc_pkg::ADDR_MCR, 8'h03);
        rreg(usfc_pkg::ADDR_MSR, 8'h00, 8'hf0);
        chk({rts_n, dtr_n}, 2'b00);
        // flow character selection
        wreg(usfc_pkg::ADDR_XCHAR1, 8'h3c);
        wreg(usfc_pkg::ADDR_XCHAR2, 8'hc3);
        chk(flow_chars, 16'h3cc3);
        for (n = 0; n < 4; n++) begin
            wreg(usfc_pkg::ADDR_EFR, 8'(n * 5));
            chk({tx_flow_sel, rx_cmp_sel}, n * 5);
            chk(dual_seq, n == 3);
        end
        // receive status per head character
        for (n = 0; n < 3; n++) begin
            wreg(usfc_pkg::ADDR_RXPUSH, etag[n]);
            rreg(usfc_pkg::ADDR_LSR, elsr[n]);
            rreg(usfc_pkg::ADDR_RXPOP, 8'h3c);
            rreg(usfc_pkg::ADDR_LSR, 8'h60);
        end
        for (n = 0; n < 17; n++) wreg(usfc_pkg::ADDR_RXPUSH, 8'h00);
        rreg(usfc_pkg::ADDR_LSR, 8'h63);
        for (n = 0; n < 16; n++) rreg(usfc_pkg::ADDR_RXPOP, 8'h3c);
        rreg(usfc_pkg::ADDR_LSR, 8'h60);
        // transmit holding and shifter
        tsr_busy <= 1'b1;
        wreg(usfc_pkg::ADDR_TXCTRL, 8'ha5);
        rreg(usfc_pkg::ADDR_LSR, 8'h00, 8'h60);
        tsr_busy <= 1'b0;
        rreg(usfc_pkg::ADDR_LSR, 8'h20, 8'h60);
        chk(tsr_data, 8'ha5);
        tsr_done <= 1'b1;
        @(posedge clock);
        tsr_done <= 1'b0;
        rreg(usfc_pkg::ADDR_LSR, 8'h60, 8'h60);
        wreg(usfc_pkg::ADDR_EFR, 8'h80);
        wreg(usfc_pkg::ADDR_TXCTRL, 8'h5a);
        repeat (8) @(posedge clock);
        rreg(usfc_pkg::ADDR_LSR, 8'h00, 8'h60);
        ml(4'h7);
        rreg(usfc_pkg::ADDR_LSR, 8'h20, 8'h60);
        chk(tsr_data, 8'h5a);
        wreg(usfc_pkg::ADDR_IER, 8'h02);
        chk(thr_irq, 1'b1);
        summarize();
    end
endmodule
